// [design/atl_map.vh]
/*
 * Constant map for the axis travel limit monitor: parameter offsets,
 * reset values, field codes, absolute range and latched flag positions.
 * Assumes it is included by bare name from the design files that need it.
 */
`ifndef ATL_MAP_VH
`define ATL_MAP_VH

// ------------------------------------------------------------
// Parameter offsets
// ------------------------------------------------------------
`define ATL_OFS_SOFT_SEL     16'h0606
`define ATL_OFS_SOFT_POS     16'h0608
`define ATL_OFS_SOFT_NEG     16'h060a
`define ATL_OFS_HOME_POL     16'h061c
`define ATL_OFS_NEG_POL      16'h061e
`define ATL_OFS_POS_POL      16'h0620

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ATL_RST_SOFT_SEL     16'h0000
`define ATL_RST_SOFT_POS     32'h7fffffff
`define ATL_RST_SOFT_NEG     32'h80000000
`define ATL_RST_POL          16'h0001

// ------------------------------------------------------------
// Field codes
// ------------------------------------------------------------
`define ATL_SEL_NONE         2'h0
`define ATL_SEL_POS          2'h1
`define ATL_SEL_NEG          2'h2
`define ATL_SEL_BOTH         2'h3
`define ATL_SEL_MAX          16'h0003
`define ATL_POL_OFF          2'h0
`define ATL_POL_NC           2'h1
`define ATL_POL_NO           2'h2
`define ATL_POL_MAX          16'h0002

// ------------------------------------------------------------
// Absolute positioning range (-286435456 .. 286435455 user units)
// ------------------------------------------------------------
`define ATL_ABS_MIN          32'heeed5780
`define ATL_ABS_MAX          32'h1112a87f

// ------------------------------------------------------------
// Latched signal flag bits
// ------------------------------------------------------------
`define ATL_FLG_POS_END      0
`define ATL_FLG_NEG_END      1
`define ATL_FLG_SOFT         2
`define ATL_FLG_REF_LOST     3

`endif

// [design/atl_soft_bound.v]
/*
 * Software travel bound check: clamps both bounds into the absolute
 * range and compares the position controller setpoint against them.
 * Assumes bounds and setpoint are signed user units relative to zero.
 */
`timescale 1ns/1ps
`default_nettype none
`include "atl_map.vh"

module atl_soft_bound (
	// Configuration
	input  wire [31:0] bound_pos,
	input  wire [31:0] bound_neg,
	input  wire [1:0]  select,
	input  wire        ref_ok,
	// Setpoint
	input  wire [31:0] setpoint,
	// Results
	output wire        hit_pos,
	output wire        hit_neg
);

	// Keeps a bound inside the permissible user range.
	function [31:0] clamp;
		input [31:0] v;
		begin
			if ($signed(v) > $signed(`ATL_ABS_MAX))
				clamp = `ATL_ABS_MAX;
			else if ($signed(v) < $signed(`ATL_ABS_MIN))
				clamp = `ATL_ABS_MIN;
			else
				clamp = v;
		end
	endfunction

	wire [31:0] eff_pos;
	wire [31:0] eff_neg;

	assign eff_pos = clamp(bound_pos);
	assign eff_neg = clamp(bound_neg);

	assign hit_pos = ref_ok && select[0] && ($signed(setpoint) > $signed(eff_pos));
	assign hit_neg = ref_ok && select[1] && ($signed(setpoint) < $signed(eff_neg));

endmodule
`default_nettype wire

// [design/atl_switch_eval.v]
/*
 * Evaluates one switch pin: two-stage synchroniser, then the
 * configured polarity decode. Assumes the pin is asynchronous to
 * core_clk and that the mode code was range-checked on write.
 */
`timescale 1ns/1ps
`default_nettype none
`include "atl_map.vh"

module atl_switch_eval (
	// Clock and reset
	input  wire       core_clk,
	input  wire       srst,
	// Pin and configuration
	input  wire       pin,
	input  wire [1:0] mode,
	input  wire       eval_en,
	// Result
	output reg        active_r
);

	reg sync1_r;
	reg sync2_r;

	// Synchroniser; the first stage is read only by the second.
	always @(posedge core_clk) begin
		if (srst) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else begin
			sync1_r <= pin;
			sync2_r <= sync1_r;
		end
	end

	// Polarity decode. A broken NC wire reads low and so trips.
	always @(posedge core_clk) begin
		if (srst) begin
			active_r <= 1'b0;
		end else if (!eval_en) begin
			active_r <= 1'b0;
		end else begin
			case (mode)
				`ATL_POL_NC: active_r <= ~sync2_r;
				`ATL_POL_NO: active_r <= sync2_r;
				default:     active_r <= 1'b0;
			endcase
		end
	end

endmodule
`default_nettype wire

// [design/atl_travel_monitor.v]
/*
 * Axis travel limit monitor: absolute range, reference validity,
 * software travel bounds, end and home switches, position readout and
 * the parameter access port.
 * Assumes the motion side runs on CORE_CLK and the switch pins are
 * asynchronous. Motion strobes are single-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "atl_map.vh"

// Notes on behaviour
// - Absolute range is -286435456 to 286435455 user units.
// - Overshoot allowed except during absolute profile positioning.
// - Running past an absolute limit clears reference valid.
// - Relative move whose target exceeds range zeroes position, drops reference.
// - Software bounds act only while reference valid, relative to zero.
// - Setpoint, not measured position, is compared against software bounds.
// - A software bound trip sets bit 2 of latched flags.
// - Positive bound defaults to 2147483647 and is clamped internally.
// - Negative bound defaults to -2147483648 and is clamped alike.
// - Bound select: 0 none, 1 positive, 2 negative, 3 both.
// - During motion an active end switch stops the motor and is flagged.
// - End switch mode: 0 off, 1 normally closed, 2 normally open.
// - Home switch 1 NC or 2 NO, read only during reference moves.
// - After an end switch stop, motion back away remains allowed.
// - Current motor position is readable in user units.
// - Dimension setting loads position with the preset and sets zero.
module atl_travel_monitor (
	// Clock and reset
	input  wire        CORE_CLK,
	input  wire        SRST,
	// Parameter access port
	input  wire [15:0] PAR_ADDR,
	input  wire        PAR_WE,
	input  wire        PAR_RE,
	input  wire [31:0] PAR_WDATA,
	output reg  [31:0] PAR_RDATA,
	output reg         PAR_RACK,
	output reg         PAR_ERR,
	// Motion profile and position controller
	input  wire [31:0] SETPOINT,
	input  wire        POS_INC_VALID,
	input  wire [15:0] POS_INC,
	input  wire        MOVE_ACTIVE,
	input  wire        MOVE_DIR_POS,
	input  wire        PP_ABS_MODE,
	input  wire        REL_START,
	input  wire [31:0] REL_DIST,
	output reg         REL_GO,
	// Homing
	input  wire        DIM_SET,
	input  wire [31:0] PRESET_POSITION_VALUE,
	input  wire        HOME_DONE,
	input  wire        HOMING_TO_REF,
	output wire        HOME_SWITCH_HIT,
	// Switch pins
	input  wire        POS_END_SWITCH_IN,
	input  wire        NEG_END_SWITCH_IN,
	input  wire        HOME_SWITCH_IN,
	// Status and stop
	output reg  [31:0] ACT_POS,
	output reg         REF_OK,
	output wire        INHIBIT_POS,
	output wire        INHIBIT_NEG,
	output reg         STOP_REQ,
	output reg  [15:0] LATCHED_SIGNAL_FLAGS,
	input  wire [15:0] FLAGS_CLR
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// True when a 33-bit signed position lies outside the absolute range.
	function out_of_range;
		input [32:0] p;
		begin
			out_of_range = ($signed(p) > $signed({1'b0, `ATL_ABS_MAX})) ||
				($signed(p) < $signed({1'b1, `ATL_ABS_MIN}));
		end
	endfunction

	// ------------------------------------------------------------
	// Parameter registers
	// ------------------------------------------------------------

	reg  [15:0] soft_bound_select_r;
	reg  [31:0] soft_bound_positive_r;
	reg  [31:0] soft_bound_negative_r;
	reg  [15:0] home_switch_polarity_r;
	reg  [15:0] neg_end_switch_polarity_r;
	reg  [15:0] pos_end_switch_polarity_r;

	wire        hit_sel;
	wire        hit_pos_b;
	wire        hit_neg_b;
	wire        hit_hpol;
	wire        hit_npol;
	wire        hit_ppol;
	wire        addr_ok;
	wire        sel_ok;
	wire        pol_ok;

	assign hit_sel   = (PAR_ADDR == `ATL_OFS_SOFT_SEL);
	assign hit_pos_b = (PAR_ADDR == `ATL_OFS_SOFT_POS);
	assign hit_neg_b = (PAR_ADDR == `ATL_OFS_SOFT_NEG);
	assign hit_hpol  = (PAR_ADDR == `ATL_OFS_HOME_POL);
	assign hit_npol  = (PAR_ADDR == `ATL_OFS_NEG_POL);
	assign hit_ppol  = (PAR_ADDR == `ATL_OFS_POS_POL);
	assign addr_ok   = hit_sel | hit_pos_b | hit_neg_b | hit_hpol | hit_npol | hit_ppol;
	assign sel_ok    = (PAR_WDATA[31:16] == 16'h0000) && (PAR_WDATA[15:0] <= `ATL_SEL_MAX);
	assign pol_ok    = (PAR_WDATA[31:16] == 16'h0000) && (PAR_WDATA[15:0] <= `ATL_POL_MAX);

	// Writes. Codes outside a field's range are refused so that a stray
	// value can never leave a switch half configured.
	always @(posedge CORE_CLK) begin
		if (SRST) begin
			soft_bound_select_r       <= `ATL_RST_SOFT_SEL;
			soft_bound_positive_r     <= `ATL_RST_SOFT_POS;
			soft_bound_negative_r     <= `ATL_RST_SOFT_NEG;
			home_switch_polarity_r    <= `ATL_RST_POL;
			neg_end_switch_polarity_r <= `ATL_RST_POL;
			pos_end_switch_polarity_r <= `ATL_RST_POL;
		end else if (PAR_WE) begin
			if (hit_sel && sel_ok) begin
				soft_bound_select_r <= PAR_WDATA[15:0];
			end else if (hit_pos_b) begin
				soft_bound_positive_r <= PAR_WDATA;
			end else if (hit_neg_b) begin
				soft_bound_negative_r <= PAR_WDATA;
			end else if (hit_hpol && pol_ok && (PAR_WDATA[1:0] != `ATL_POL_OFF)) begin
				home_switch_polarity_r <= PAR_WDATA[15:0];
			end else if (hit_npol && pol_ok) begin
				neg_end_switch_polarity_r <= PAR_WDATA[15:0];
			end else if (hit_ppol && pol_ok) begin
				pos_end_switch_polarity_r <= PAR_WDATA[15:0];
			end
		end
	end

	// Read data and acknowledge; unmapped accesses answer with an error pulse.
	always @(posedge CORE_CLK) begin
		if (SRST) begin
			PAR_RDATA <= 32'h00000000;
			PAR_RACK  <= 1'b0;
			PAR_ERR   <= 1'b0;
		end else begin
			PAR_RACK <= PAR_RE && addr_ok;
			PAR_ERR  <= (PAR_RE || PAR_WE) && !addr_ok;
			if (PAR_RE) begin
				if (hit_sel)
					PAR_RDATA <= {16'h0000, soft_bound_select_r};
				else if (hit_pos_b)
					PAR_RDATA <= soft_bound_positive_r;
				else if (hit_neg_b)
					PAR_RDATA <= soft_bound_negative_r;
				else if (hit_hpol)
					PAR_RDATA <= {16'h0000, home_switch_polarity_r};
				else if (hit_npol)
					PAR_RDATA <= {16'h0000, neg_end_switch_polarity_r};
				else if (hit_ppol)
					PAR_RDATA <= {16'h0000, pos_end_switch_polarity_r};
				else
					PAR_RDATA <= 32'h00000000;
			end
		end
	end

	// ------------------------------------------------------------
	// Switch evaluation
	// ------------------------------------------------------------

	wire pos_sw_active;
	wire neg_sw_active;
	wire home_sw_active;

	atl_switch_eval u_pos_sw (
		.core_clk (CORE_CLK),
		.srst     (SRST),
		.pin      (POS_END_SWITCH_IN),
		.mode     (pos_end_switch_polarity_r[1:0]),
		.eval_en  (1'b1),
		.active_r (pos_sw_active)
	);

	atl_switch_eval u_neg_sw (
		.core_clk (CORE_CLK),
		.srst     (SRST),
		.pin      (NEG_END_SWITCH_IN),
		.mode     (neg_end_switch_polarity_r[1:0]),
		.eval_en  (1'b1),
		.active_r (neg_sw_active)
	);

	// home switch read only while homing
	atl_switch_eval u_home_sw (
		.core_clk (CORE_CLK),
		.srst     (SRST),
		.pin      (HOME_SWITCH_IN),
		.mode     (home_switch_polarity_r[1:0]),
		.eval_en  (HOMING_TO_REF),
		.active_r (home_sw_active)
	);

	assign HOME_SWITCH_HIT = home_sw_active;

	// ------------------------------------------------------------
	// Software travel bounds
	// ------------------------------------------------------------

	wire soft_hit_pos;
	wire soft_hit_neg;

	atl_soft_bound u_soft (
		.bound_pos (soft_bound_positive_r),
		.bound_neg (soft_bound_negative_r),
		.select    (soft_bound_select_r[1:0]),
		.ref_ok    (REF_OK),
		.setpoint  (SETPOINT),
		.hit_pos   (soft_hit_pos),
		.hit_neg   (soft_hit_neg)
	);

	// ------------------------------------------------------------
	// Direction blocking and stop request
	// ------------------------------------------------------------

	wire abs_hit_pos;
	wire abs_hit_neg;
	wire block_pos;
	wire block_neg;
	wire hit_now;
	reg  hit_prev_r;

	// range enforced in absolute profile mode only
	assign abs_hit_pos = PP_ABS_MODE && ($signed(SETPOINT) > $signed(`ATL_ABS_MAX));
	assign abs_hit_neg = PP_ABS_MODE && ($signed(SETPOINT) < $signed(`ATL_ABS_MIN));

	// Only the tripped direction is blocked, so a jog back
	// into the travel area is still accepted.
	assign block_pos   = pos_sw_active | soft_hit_pos | abs_hit_pos;
	assign block_neg   = neg_sw_active | soft_hit_neg | abs_hit_neg;
	assign INHIBIT_POS = block_pos;
	assign INHIBIT_NEG = block_neg;

	assign hit_now = MOVE_ACTIVE && ((MOVE_DIR_POS && block_pos) || (!MOVE_DIR_POS && block_neg));

	// The stop is a single pulse on entry, so a long stall does not keep
	// re-triggering the profile generator's stop ramp.
	always @(posedge CORE_CLK) begin
		if (SRST) begin
			hit_prev_r <= 1'b0;
			STOP_REQ   <= 1'b0;
		end else begin
			hit_prev_r <= hit_now;
			STOP_REQ   <= hit_now && !hit_prev_r;
		end
	end

	// ------------------------------------------------------------
	// Position, reference and relative move start
	// ------------------------------------------------------------

	wire [31:0] pos_step;
	wire [31:0] pos_sum;
	wire [32:0] rel_target;
	wire        rel_over;
	wire        pos_over;

	assign pos_step   = {{16{POS_INC[15]}}, POS_INC};
	assign pos_sum    = ACT_POS + pos_step;
	assign rel_target = {ACT_POS[31], ACT_POS} + {REL_DIST[31], REL_DIST};
	assign rel_over   = REL_START && out_of_range(rel_target);
	assign pos_over   = out_of_range({ACT_POS[31], ACT_POS});

	// Position register. Dimension setting takes priority over
	// motion steps because it only happens at standstill.
	always @(posedge CORE_CLK) begin
		if (SRST) begin
			ACT_POS <= 32'h00000000;
		end else if (DIM_SET) begin
			ACT_POS <= PRESET_POSITION_VALUE;
		end else if (rel_over) begin
			ACT_POS <= 32'h00000000;
		end else if (POS_INC_VALID) begin
			ACT_POS <= pos_sum;
		end
	end

	// Relative start is released one cycle later, on the same edge as any zeroing.
	always @(posedge CORE_CLK) begin
		if (SRST) begin
			REL_GO <= 1'b0;
		end else begin
			REL_GO <= REL_START;
		end
	end

	// Reference valid. A new zero point from homing or dimension setting
	// wins over a loss in the same cycle, since it redefines the position.
	always @(posedge CORE_CLK) begin
		if (SRST) begin
			REF_OK <= 1'b0;
		end else if (DIM_SET || HOME_DONE) begin
			REF_OK <= 1'b1;
		end else if (rel_over || pos_over) begin
			REF_OK <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Latched signal flags
	// ------------------------------------------------------------

	reg [15:0] flag_set;

	// Hardware events set the flags; software clears by mask.
	always @* begin
		flag_set = 16'h0000;
		flag_set[`ATL_FLG_POS_END]  = MOVE_ACTIVE && MOVE_DIR_POS && pos_sw_active;
		flag_set[`ATL_FLG_NEG_END]  = MOVE_ACTIVE && !MOVE_DIR_POS && neg_sw_active;
		flag_set[`ATL_FLG_SOFT]     = soft_hit_pos || soft_hit_neg;
		flag_set[`ATL_FLG_REF_LOST] = REF_OK && (rel_over || pos_over);
	end

	// A set in the same cycle as a clear wins, so no event is lost.
	always @(posedge CORE_CLK) begin
		if (SRST) begin
			LATCHED_SIGNAL_FLAGS <= 16'h0000;
		end else begin
			LATCHED_SIGNAL_FLAGS <= (LATCHED_SIGNAL_FLAGS & ~FLAGS_CLR) | flag_set;
		end
	end

endmodule
`default_nettype wire

// [dv/atl_switch_model.sv]
/*
 * Model of the axis switches as the installation wires them: bit 0 the
 * positive end, bit 1 the negative end, bit 2 the home switch.
 * Assumes the bench sets each contact state and its wiring kind.
 */
`timescale 1ns/1ps
`default_nettype none

module atl_switch_model (
	// Contact state and wiring kind, 1 means normally closed
	input  wire logic [2:0] hit,
	input  wire logic [2:0] nc,
	// Pins toward the monitor
	output logic      [2:0] pin
);
	// closed contact wiring
	// A closed contact holds the pin high, so a cut wire reads as a hit.
	assign pin = hit ^ nc;
endmodule

`default_nettype wire

// [dv/atl_travel_monitor_assertions.sv]
/*
 * Port checker for the travel limit monitor.
 * Assumes one clock domain and the synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module atl_travel_monitor_assertions (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        SRST,
	// Watched ports
	input  wire logic        PAR_WE, PAR_RE, PAR_RACK, PAR_ERR, POS_INC_VALID, MOVE_ACTIVE,
	input  wire logic        MOVE_DIR_POS, REL_START, REL_GO, DIM_SET, HOME_DONE, HOMING_TO_REF,
	input  wire logic        HOME_SWITCH_HIT, REF_OK, INHIBIT_POS, INHIBIT_NEG, STOP_REQ,
	input  wire logic [15:0] POS_INC, LATCHED_SIGNAL_FLAGS,
	input  wire logic [31:0] REL_DIST, PRESET_POSITION_VALUE, ACT_POS
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SRST);

	// Helper terms; the target is one bit wider so a sum cannot wrap.
	wire signed [32:0] tgt       = $signed(ACT_POS) + $signed(REL_DIST);
	wire               tgt_out   = (tgt > 33'sh0_1112a87f) || (tgt < 33'sh1_eeed5780);
	wire               pos_out   = ($signed(ACT_POS) > 32'sh1112a87f) || ($signed(ACT_POS) < 32'sheeed5780);
	wire        [31:0] inc_ext   = {{16{POS_INC[15]}}, POS_INC};
	wire               mv_pos    = INHIBIT_POS && MOVE_ACTIVE && MOVE_DIR_POS;
	wire               mv_any    = mv_pos || (INHIBIT_NEG && MOVE_ACTIVE && !MOVE_DIR_POS);
	wire               soft_hit  = REF_OK && (INHIBIT_POS || INHIBIT_NEG);

	a_rd_answer: assert property (PAR_RE |=> PAR_RACK || PAR_ERR)
		else $error("read not answered");
	a_idle_quiet: assert property (!PAR_RE && !PAR_WE |=> !PAR_RACK && !PAR_ERR)
		else $error("answer without request");
	a_rel_zero: assert property (REL_START && tgt_out && !DIM_SET && !HOME_DONE |=> ACT_POS == 32'h0 && !REF_OK)
		else $error("relative move out of range not zeroed");
	a_rel_go: assert property (REL_START |=> REL_GO)
		else $error("relative move not released");
	a_go_cause: assert property (REL_GO |-> $past(REL_START))
		else $error("move release without request");
	a_ref_lost: assert property (pos_out && !DIM_SET && !HOME_DONE |=> !REF_OK)
		else $error("reference kept past range");
	a_dim_load: assert property (DIM_SET |=> ACT_POS == $past(PRESET_POSITION_VALUE) && REF_OK)
		else $error("preset not loaded");
	a_pos_step: assert property (POS_INC_VALID && !DIM_SET && !REL_START
		|=> ACT_POS == $past(ACT_POS) + $past(inc_ext))
		else $error("position step wrong");
	a_end_flag: assert property ($rose(LATCHED_SIGNAL_FLAGS[0]) |-> $past(mv_pos))
		else $error("end flag without cause");
	a_stop_cause: assert property (STOP_REQ |-> $past(mv_any))
		else $error("stop without cause");
	a_soft_flag: assert property ($rose(LATCHED_SIGNAL_FLAGS[2]) |-> $past(soft_hit))
		else $error("soft flag without valid reference");
	a_home_gate: assert property (!HOMING_TO_REF [*3] |-> !HOME_SWITCH_HIT)
		else $error("home switch seen outside homing");

	c_rel_go: cover property (REL_GO);
	c_stop: cover property (STOP_REQ);
	c_soft: cover property ($rose(LATCHED_SIGNAL_FLAGS[2]));
	c_home: cover property (HOME_SWITCH_HIT);
endmodule

bind atl_travel_monitor atl_travel_monitor_assertions u_chk (.CORE_CLK, .SRST, .PAR_WE, .PAR_RE,
	.PAR_RACK, .PAR_ERR, .POS_INC_VALID, .MOVE_ACTIVE, .MOVE_DIR_POS, .REL_START, .REL_GO, .DIM_SET,
	.HOME_DONE, .HOMING_TO_REF, .HOME_SWITCH_HIT, .REF_OK, .INHIBIT_POS, .INHIBIT_NEG, .STOP_REQ,
	.POS_INC, .LATCHED_SIGNAL_FLAGS, .REL_DIST, .PRESET_POSITION_VALUE, .ACT_POS);

`default_nettype wire

// [dv/atl_travel_monitor_test.sv]
/*
 * Self-checking bench for the travel limit monitor.
 * Assumes the switch model drives the pins and the checker is bound in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "atl_map.vh"

module atl_travel_monitor_test;
	// Stimulus toward the monitor.
	logic        CORE_CLK = 1'b0, SRST = 1'b1, PAR_WE = 1'b0, PAR_RE = 1'b0;
	logic        POS_INC_VALID = 1'b0, MOVE_ACTIVE = 1'b0, MOVE_DIR_POS = 1'b0, PP_ABS_MODE = 1'b0;
	logic        REL_START = 1'b0, DIM_SET = 1'b0, HOME_DONE = 1'b0, HOMING_TO_REF = 1'b0;
	logic [15:0] PAR_ADDR = 16'h0, POS_INC = 16'h0, FLAGS_CLR = 16'h0;
	logic [31:0] PAR_WDATA = 32'h0, SETPOINT = 32'h0, REL_DIST = 32'h0, PRESET_POSITION_VALUE = 32'h0;
	logic [2:0]  hit = 3'h0, nc = 3'h7;
	// Answers from the monitor and the pins.
	wire  [31:0] PAR_RDATA, ACT_POS;
	wire  [15:0] LATCHED_SIGNAL_FLAGS;
	wire         PAR_RACK, PAR_ERR, REL_GO, HOME_SWITCH_HIT, REF_OK, INHIBIT_POS, INHIBIT_NEG, STOP_REQ;
	wire  [2:0]  pin;
	int          err_count = 0, tests_run = 0, stops = 0, seed = 63, i, b, s, p, r;
	// Select, setpoint, expected positive and negative inhibit.
	logic [39:0] sb_tbl [6] = '{40'h3_1112a87f_0, 40'h3_1112a880_2, 40'h2_1112a880_0,
		40'h2_eeed577f_1, 40'h1_eeed577f_0, 40'h0_1112a880_0};

	always #25 CORE_CLK = ~CORE_CLK;
	// Stop pulses are counted so a scenario can look back at them.
	always @(posedge CORE_CLK) if (STOP_REQ === 1'b1) stops++;

	atl_switch_model sw (.hit(hit), .nc(nc), .pin(pin));
	atl_travel_monitor dut (.CORE_CLK, .SRST, .PAR_ADDR, .PAR_WE, .PAR_RE, .PAR_WDATA, .PAR_RDATA,
		.PAR_RACK, .PAR_ERR, .SETPOINT, .POS_INC_VALID, .POS_INC, .MOVE_ACTIVE, .MOVE_DIR_POS,
		.PP_ABS_MODE, .REL_START, .REL_DIST, .REL_GO, .DIM_SET, .PRESET_POSITION_VALUE, .HOME_DONE,
		.HOMING_TO_REF, .HOME_SWITCH_HIT, .POS_END_SWITCH_IN(pin[0]), .NEG_END_SWITCH_IN(pin[1]),
		.HOME_SWITCH_IN(pin[2]), .ACT_POS, .REF_OK, .INHIBIT_POS, .INHIBIT_NEG, .STOP_REQ,
		.LATCHED_SIGNAL_FLAGS, .FLAGS_CLR);

	// Wide enough that a packed status word plus a 32-bit position is compared whole.
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		PAR_WE <= 1'b1;
		PAR_ADDR <= a;
		PAR_WDATA <= d;
		@(posedge CORE_CLK);
		PAR_WE <= 1'b0;
	endtask

	// The answer stands one cycle, so it is looked at just after its edge.
	task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic er);
		@(posedge CORE_CLK);
		PAR_RE <= 1'b1;
		PAR_ADDR <= a;
		@(posedge CORE_CLK);
		PAR_RE <= 1'b0;
		#1;
		chk({PAR_RACK, PAR_ERR}, {!er, er});
		if (!er) chk(PAR_RDATA, e);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge CORE_CLK);
		SRST <= 1'b0;
		rd(`ATL_OFS_SOFT_SEL, 32'h0, 1'b0);
		rd(`ATL_OFS_SOFT_POS, `ATL_RST_SOFT_POS, 1'b0);
		rd(`ATL_OFS_SOFT_NEG, `ATL_RST_SOFT_NEG, 1'b0);
		rd(`ATL_OFS_HOME_POL, 32'h1, 1'b0);
		rd(`ATL_OFS_NEG_POL, 32'h1, 1'b0);
		rd(`ATL_OFS_POS_POL, 32'h1, 1'b0);
		rd(16'h0600, 32'h0, 1'b1);
		// Every select and positive end switch code reads back; out-of-range codes and home code 0 leave the field alone.
		for (i = 0; i < 4; i++) begin
			wr(`ATL_OFS_SOFT_SEL, i);
			rd(`ATL_OFS_SOFT_SEL, i, 1'b0);
		end
		wr(`ATL_OFS_SOFT_SEL, 32'h4);
		rd(`ATL_OFS_SOFT_SEL, 32'h3, 1'b0);
		for (i = 2; i >= 0; i--) begin
			wr(`ATL_OFS_POS_POL, i);
			rd(`ATL_OFS_POS_POL, i, 1'b0);
		end
		wr(`ATL_OFS_POS_POL, 32'h3);
		rd(`ATL_OFS_POS_POL, 32'h0, 1'b0);
		wr(`ATL_OFS_HOME_POL, 32'h0);
		rd(`ATL_OFS_HOME_POL, 32'h1, 1'b0);
		$display("done: parameter access");
		// Bounds wait for a zero point, then follow the setpoint alone.
		wr(`ATL_OFS_SOFT_POS, 32'h1000);
		MOVE_ACTIVE <= 1'b1;
		MOVE_DIR_POS <= 1'b1;
		SETPOINT <= 32'h1001;
		@(posedge CORE_CLK);
		#1 chk(INHIBIT_POS, 1'b0);
		s = stops;
		HOME_DONE <= 1'b1;
		@(posedge CORE_CLK);
		HOME_DONE <= 1'b0;
		#1 chk({REF_OK, INHIBIT_POS, ACT_POS}, {2'b11, 32'h0});
		repeat (3) @(posedge CORE_CLK);
		#1 chk({stops != s, LATCHED_SIGNAL_FLAGS[2]}, 2'b11);
		for (i = 0; i < 8; i++) begin
			b = $random(seed) % 200000000;
			s = b + i % 3 - 1;
			wr(`ATL_OFS_SOFT_POS, b);
			SETPOINT <= s;
			#1 chk(INHIBIT_POS, s > b);
		end
		wr(`ATL_OFS_SOFT_POS, 32'h7fffffff);
		for (i = 0; i < 6; i++) begin
			wr(`ATL_OFS_SOFT_SEL, sb_tbl[i][39:36]);
			SETPOINT <= sb_tbl[i][35:4];
			#1 chk({INHIBIT_POS, INHIBIT_NEG}, sb_tbl[i][1:0]);
		end
		SETPOINT <= 32'h0;
		$display("done: soft bounds");
		// Positive end switch in each mode; the way back stays open.
		for (i = 0; i < 3; i++) begin
			wr(`ATL_OFS_POS_POL, i);
			FLAGS_CLR <= 16'hffff;
			nc[0] <= (i == 1);
			hit[0] <= 1'b1;
			s = stops;
			@(posedge CORE_CLK);
			FLAGS_CLR <= 16'h0;
			repeat (5) @(posedge CORE_CLK);
			#1 chk({INHIBIT_POS, stops != s, LATCHED_SIGNAL_FLAGS[0]}, {3{i != 0}});
			chk(INHIBIT_NEG, 1'b0);
			hit[0] <= 1'b0;
			repeat (4) @(posedge CORE_CLK);
		end
		MOVE_DIR_POS <= 1'b0;
		hit[1] <= 1'b1;
		repeat (5) @(posedge CORE_CLK);
		#1 chk({INHIBIT_NEG, LATCHED_SIGNAL_FLAGS[1]}, 2'b11);
		hit <= 3'h4;
		repeat (5) @(posedge CORE_CLK);
		#1 chk(HOME_SWITCH_HIT, 1'b0);
		HOMING_TO_REF <= 1'b1;
		repeat (5) @(posedge CORE_CLK);
		#1 chk(HOME_SWITCH_HIT, 1'b1);
		// A touched home contact wired normally closed but set to normally open reads as idle.
		wr(`ATL_OFS_HOME_POL, 32'h2);
		repeat (2) @(posedge CORE_CLK);
		#1 chk(HOME_SWITCH_HIT, 1'b0);
		HOMING_TO_REF <= 1'b0;
		hit <= 3'h0;
		MOVE_ACTIVE <= 1'b0;
		$display("done: switches");
		// Random steps, preset load, overshoot and relative moves.
		p = 0;
		for (i = 0; i < 8; i++) begin
			@(posedge CORE_CLK);
			r = $random(seed);
			POS_INC_VALID <= 1'b1;
			POS_INC <= r[15:0];
			p = p + $signed(r[15:0]);
		end
		@(posedge CORE_CLK);
		POS_INC_VALID <= 1'b0;
		PRESET_POSITION_VALUE <= 32'h1112a87f;
		DIM_SET <= 1'b1;
		#1 chk(ACT_POS, p[31:0]);
		@(posedge CORE_CLK);
		DIM_SET <= 1'b0;
		POS_INC_VALID <= 1'b1;
		POS_INC <= 16'h1;
		#1 chk({REF_OK, ACT_POS}, {1'b1, 32'h1112a87f});
		@(posedge CORE_CLK);
		POS_INC_VALID <= 1'b0;
		@(posedge CORE_CLK);
		#1 chk({REF_OK, ACT_POS}, {1'b0, 32'h1112a880});
		PRESET_POSITION_VALUE <= 32'h1112a000;
		DIM_SET <= 1'b1;
		@(posedge CORE_CLK);
		DIM_SET <= 1'b0;
		REL_START <= 1'b1;
		// The clear meets the reference loss on one edge; the loss must stay latched.
		FLAGS_CLR <= 16'hffff;
		REL_DIST <= 32'h1000;
		@(posedge CORE_CLK);
		REL_DIST <= 32'h5;
		FLAGS_CLR <= 16'h0;
		#1 chk({REL_GO, REF_OK, LATCHED_SIGNAL_FLAGS[3], ACT_POS}, {3'b101, 32'h0});
		@(posedge CORE_CLK);
		REL_START <= 1'b0;
		#1 chk({REL_GO, ACT_POS}, {1'b1, 32'h0});
		$display("done: position");
		// Overshoot is refused only under absolute profile positioning.
		SETPOINT <= 32'h1112a880;
		for (i = 0; i < 2; i++) begin
			@(posedge CORE_CLK);
			PP_ABS_MODE <= i;
			#1 chk(INHIBIT_POS, 1'b0 | i);
		end
		$display("done: absolute range");
		results();
	end
endmodule

`default_nettype wire
